/* File: hw/acle_alu.sv */
// Byte adder and logic unit with flag generation
`timescale 1ns/1ps
`default_nettype none
module acle_alu
   import acle_pkg::*;
(
   // Operands
   input wire logic [7:0] opA,
   input wire logic [7:0] opB,
   input wire logic carryIn,
   input wire logic doAnd,
   // Results
   output logic [7:0] result,
   output logic negFlag,
   output logic overflowFlag,
   output logic carryFlag,
   output logic digitCarryFlag,
   output logic zeroFlag
);
   logic [4:0] lowSum;
   logic [8:0] fullSum;
   logic [7:0] sum;

   // ==========================================
   // Sum and flags
   always_comb begin
      lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
      fullSum = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
      sum = fullSum[7:0];
      result = doAnd ? (opA & opB) : sum;
      negFlag = result[7];
      zeroFlag = (result == 8'h00);
      carryFlag = fullSum[8];
      digitCarryFlag = lowSum[4];
      overflowFlag = (opA[7] == opB[7]) && (sum[7] != opA[7]);
   end
endmodule
`default_nettype wire

/* File: hw/acle_exec.sv */
// Execution unit for add, add-with-carry and AND-literal instructions
// Behaviour
// - Add-with-carry sums W, file byte and carry; updates N, OV, C, DC, Z.
// - Add-with-carry opcode 0010 00da ffff; d=0 writes W, d=1 writes file.
// - a=0 selects access bank; a=1 uses bank select register.
// - Extended set, a=0, f<=95 uses indexed literal offset addressing.
// - AND-literal opcode 0000 1011 kkkk; ANDs into W; updates N and Z.
// - Q1 decode, Q2 read file, Q3 process, Q4 write destination.
// - Plain add opcode 0010 01da ffff; no carry-in; d and a as above.
`timescale 1ns/1ps
`default_nettype none
module acle_exec
   import acle_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Instruction in, one word per cycle of four phases
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic extendedSetEn,
   input wire logic [3:0] bank_select_register,
   input wire logic [11:0] fsrTwo,
   // Incoming status flags
   input wire logic carryIn,
   // Data memory port
   output logic [11:0] memAddr,
   output logic memRead,
   input wire logic [7:0] memRdata,
   output logic memWrite,
   output logic [7:0] memWdata,
   // Working register and status out
   output logic [7:0] wreg,
   output logic flagWrite,
   output logic [4:0] flagMask,
   output logic negFlag,
   output logic overflow_flag,
   output logic carryFlag,
   output logic digit_carry_flag,
   output logic zeroFlag,
   output logic [1:0] phase,
   output logic busy
);
   typedef enum logic [1:0] {ACLE_NONE, ACLE_ADD, ACLE_ADDC, ACLE_ANDL} acle_op_t;

   acle_phase_t phase_q;
   acle_op_t op_q;
   logic [15:0] instr_q;
   logic [7:0] operand_q;
   logic [7:0] res_q;
   logic [4:0] flags_q;
   logic active_q;
   logic [7:0] wreg_q;
   logic [7:0] aluRes;
   logic aN, aOv, aC, aDc, aZ;
   logic [11:0] addr_q;
   logic [4:0] mask_q;
   logic destW_q;
   logic carry_q;

   // ==========================================
   // Decode helper
   function automatic acle_op_t decodeOp(input logic [15:0] w);
      if ((w[15:8] & OP_ADD_CARRY_MASK) == OP_ADD_CARRY)
         return ACLE_ADDC;
      else if ((w[15:8] & OP_ADD_MASK) == OP_ADD)
         return ACLE_ADD;
      else if (w[15:8] == OP_AND_LIT)
         return ACLE_ANDL;
      else
         return ACLE_NONE;
   endfunction

   // ==========================================
   // Address formation
   function automatic logic [11:0] formAddr(input logic [15:0] w,
      input logic [3:0] bank, input logic [11:0] base, input logic ext);
      logic [7:0] f;
      f = w[7:0];
      if (w[BIT_ACCESS + 8]) begin
         return {bank, f};
      end else if (ext && f <= IDX_LIMIT) begin
         return base + {4'h0, f};
      end else if (f < ACCESS_SPLIT) begin
         return {4'h0, f};
      end else begin
         return {ACCESS_HIGH_BANK, f};
      end
   endfunction

   // ==========================================
   // Phase sequencer
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase_q <= ACLE_Q1;
      end else begin
         phase_q <= acle_phase_t'(phase_q + 2'h1);
      end
   end

   // ==========================================
   // Q1 decode
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         op_q <= ACLE_NONE;
         instr_q <= 16'h0000;
         active_q <= 1'b0;
      end else if (phase_q == ACLE_Q1) begin
         op_q <= instrValid ? decodeOp(instrWord) : ACLE_NONE;
         instr_q <= instrWord;
         active_q <= instrValid && (decodeOp(instrWord) != ACLE_NONE);
      end else if (phase_q == ACLE_Q4) begin
         active_q <= 1'b0;
      end
   end

   // ==========================================
   // Q1 effective address capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addr_q <= 12'h000;
      end else if (phase_q == ACLE_Q1) begin
         addr_q <= formAddr(instrWord, bank_select_register, fsrTwo,
            extendedSetEn);
      end
   end

   // ==========================================
   // Q1 flag mask and destination capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mask_q <= 5'h00;
         destW_q <= 1'b0;
      end else if (phase_q == ACLE_Q1) begin
         mask_q <= (decodeOp(instrWord) == ACLE_ANDL) ? 5'h11 : 5'h1f;
         destW_q <= (decodeOp(instrWord) == ACLE_ANDL)
            || !instrWord[BIT_DEST + 8];
      end
   end

   // ==========================================
   // Q1 carry capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         carry_q <= 1'b0;
      end else if (phase_q == ACLE_Q1) begin
         carry_q <= (decodeOp(instrWord) == ACLE_ADDC) && carryIn;
      end
   end

   // ==========================================
   // Q2 operand read
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         operand_q <= 8'h00;
      end else if (phase_q == ACLE_Q2) begin
         operand_q <= (op_q == ACLE_ANDL) ? instr_q[7:0] : memRdata;
      end
   end

   acle_alu u_alu (
      .opA(wreg_q),
      .opB(operand_q),
      .carryIn(carry_q),
      .doAnd(op_q == ACLE_ANDL),
      .result(aluRes),
      .negFlag(aN),
      .overflowFlag(aOv),
      .carryFlag(aC),
      .digitCarryFlag(aDc),
      .zeroFlag(aZ)
   );

   // ==========================================
   // Q3 process
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         res_q <= 8'h00;
         flags_q <= 5'h00;
      end else if (phase_q == ACLE_Q3) begin
         res_q <= aluRes;
         flags_q <= {aN, aOv, aC, aDc, aZ};
      end
   end

   // ==========================================
   // Q4 write working register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wreg_q <= WREG_RESET;
      end else if (phase_q == ACLE_Q4 && active_q) begin
         if (destW_q) begin
            wreg_q <= res_q;
         end
      end
   end

   // ==========================================
   // Memory port
   always_comb begin
      memAddr = addr_q;
      memRead = (phase_q == ACLE_Q2) && active_q
         && (op_q != ACLE_ANDL);
      memWrite = (phase_q == ACLE_Q4) && active_q && !destW_q;
      memWdata = res_q;
   end

   // ==========================================
   // Working register and status
   always_comb begin
      flagWrite = (phase_q == ACLE_Q4) && active_q;
      flagMask = mask_q;
      wreg = wreg_q;
      negFlag = flags_q[4];
      overflow_flag = flags_q[3];
      carryFlag = flags_q[2];
      digit_carry_flag = flags_q[1];
      zeroFlag = flags_q[0];
   end

   // ==========================================
   // Sequencer view
   always_comb begin
      phase = phase_q;
      busy = active_q;
   end
endmodule
`default_nettype wire

/* File: include/acle_pkg.sv */
// Constants for the add, add-with-carry and AND-literal execution block
package acle_pkg;
   // Opcode top-byte patterns and masks
   localparam logic [7:0] OP_ADD_CARRY_MASK = 8'hfc;
   localparam logic [7:0] OP_ADD_CARRY = 8'h20;
   localparam logic [7:0] OP_ADD_MASK = 8'hfc;
   localparam logic [7:0] OP_ADD = 8'h24;
   localparam logic [7:0] OP_AND_LIT = 8'h0b;
   // Field positions inside the top byte
   localparam int BIT_DEST = 1;
   localparam int BIT_ACCESS = 0;
   // Indexed literal offset limit (f <= 95)
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   // Access bank split, high bank and address width
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   localparam int ADDR_W = 12;
   // Reset values
   localparam logic [7:0] WREG_RESET = 8'h00;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   // Quarter-cycle phases
   typedef enum logic [1:0] {
      ACLE_Q1,
      ACLE_Q2,
      ACLE_Q3,
      ACLE_Q4
   } acle_phase_t;
endpackage

/* File: verification/acle_exec_bench.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module acle_exec_bench;
   import acle_pkg::*;
   logic clk_sys = 0, rstn = 0, instrValid = 0, extendedSetEn = 0;
   logic carryIn = 0, memRead, memWrite, flagWrite, busy, chkW = 0;
   logic negFlag, overflow_flag, carryFlag, digit_carry_flag, zeroFlag;
   logic [15:0] instrWord = 0;
   logic [3:0] bank_select_register = 0;
   logic [11:0] fsrTwo = 0, memAddr, ea;
   logic [7:0] memRdata, memWdata, wreg, w = 0, m, f, res, op;
   logic [4:0] flagMask, fl;
   logic [1:0] phase;
   logic [8:0] s;
   logic [39:0] note [$], n;
   logic [31:0] rnd = 61;
   logic [7:0] ops [4] = '{OP_ADD_CARRY, OP_ADD, OP_AND_LIT, 8'hff};
   int fail_count = 0, comparisons = 0, i;
   always #5 clk_sys = ~clk_sys;
   assign memRdata = memAddr[7:0] ^ 8'ha5;
   acle_exec i_acle_exec (.*);
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic chk(string nm, logic [30:0] e, logic [30:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Monitor
   always @(negedge clk_sys) begin
      if (chkW) chk("wreg", n[7:0], wreg);
      chkW = 0;
      if (flagWrite === 1'b1 && note.size() == 0) chk("strobe", 0, 1);
      else if (flagWrite === 1'b1) begin
         n = note.pop_front();
         chk("result", n[38:8], {memAddr, memWrite, memWdata, flagMask &
            {negFlag, overflow_flag, carryFlag, digit_carry_flag, zeroFlag},
            flagMask} & (n[39] ? 31'h7fffffff : 31'h403ff));
         chkW = 1;
      end
   end
   initial begin
      #5000;
      fail_count++;
      finish_test();
   end
   // Stimulus
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 rstn = 1;
      for (i = 0; i < 60; i++) begin
         rnd = xs(rnd);
         f = i[0] ? 8'h5f + i[1] : rnd[7:0];
         op = ops[rnd[9:8]];
         if (op[7:3] == 5'h04) op[1:0] = rnd[11:10];
         instrWord = {op, f};
         {extendedSetEn, carryIn, bank_select_register} = rnd[17:12];
         fsrTwo = rnd[29:18];
         instrValid = 1;
         if (op[7:3] == 5'h04) begin
            ea = op[0] ? {bank_select_register, f} :
               (extendedSetEn && f <= IDX_LIMIT) ? fsrTwo + f :
               {f < ACCESS_SPLIT ? 4'h0 : ACCESS_HIGH_BANK, f};
            m = ea[7:0] ^ 8'ha5;
            s = w + m + (op[2] ? 1'b0 : carryIn);
            res = s[7:0];
            fl = {res[7], w[7] == m[7] && res[7] != w[7], s[8],
               (w[3:0] + m[3:0] + (op[2] ? 0 : carryIn)) > 15, res == 0};
            if (!op[1]) w = res;
            note.push_back({1'b1, ea, op[1], res, fl, 5'h1f, w});
         end else if (op == OP_AND_LIT) begin
            w = w & f;
            note.push_back({14'h0, 8'h0, w[7], 3'h0, w == 0, 5'h11, w});
         end
         @(posedge clk_sys) #1 instrValid = 0;
         repeat (3) @(posedge clk_sys);
         #1;
      end
      repeat (3) @(posedge clk_sys);
      finish_test();
   end
endmodule
`default_nettype wire

/* File: verification/acle_exec_properties.sv */
// Checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
module acle_exec_properties
   import acle_pkg::*;
(
   // Watched ports
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic extendedSetEn,
   input wire logic [3:0] bank_select_register,
   input wire logic [11:0] fsrTwo,
   input wire logic [11:0] memAddr,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic flagWrite,
   input wire logic [4:0] flagMask,
   input wire logic [1:0] phase,
   input wire logic busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic [7:0] op;
   logic tk, ad, an;
   assign op = instrWord[15:8];
   assign tk = phase == 2'h0 && instrValid;
   assign ad = (op & OP_ADD_MASK) == OP_ADD
      || (op & OP_ADD_CARRY_MASK) == OP_ADD_CARRY;
   assign an = op == OP_AND_LIT;
   chk_read_phase: assert property (memRead |-> phase == 2'h1)
      else $error("read out of phase");
   chk_write_phase: assert property (memWrite |-> flagWrite)
      else $error("write without flag strobe");
   chk_flag_phase: assert property (flagWrite |-> phase == 2'h3)
      else $error("flag strobe out of phase");
   chk_add_timing: assert property (tk && ad |=> memRead ##2
      flagMask == 5'h1f && memWrite == $past(instrWord[9], 3))
      else $error("add timing");
   chk_and_timing: assert property (tk && an |-> ##3
      flagWrite && flagMask == 5'h11 && !memWrite)
      else $error("and timing");
   chk_bank_addr: assert property (tk && ad && op[0] |=>
      memAddr == {$past(bank_select_register), $past(instrWord[7:0])})
      else $error("bank address");
   chk_index_addr: assert property (tk && ad && !op[0] &&
      extendedSetEn && instrWord[7:0] <= IDX_LIMIT |=>
      memAddr == $past(fsrTwo) + $past(instrWord[7:0]))
      else $error("indexed address");
   chk_unknown_quiet: assert property (tk && !ad && !an |=>
      !busy && !memRead ##1 !busy ##1 !flagWrite)
      else $error("unknown opcode acted");
   chk_busy_span: assert property (tk && (ad || an) |=>
      busy [*3] ##1 !flagWrite)
      else $error("busy span");
endmodule
bind acle_exec acle_exec_properties i_chk (.*);
`default_nettype wire
